/* File: hw/rmc_pkg.sv */
// Purpose: shared constants and types of the regulator mode control block
// Assumes: 25 MHz system clock, 32-bit AXI4-Lite register access
// Notes: every offset lives here, with the ctrl and mask reset values and all cycle counts but the sync window, which rmc_top derives
package rmc_pkg;
	// clock and derived delays
	localparam int CLK_PERIOD_NS = 40; // 25 MHz
	localparam int SLEEP_DLY_US = 103; // shutdown glitch filter
	localparam int SLEEP_DLY_CYC = (SLEEP_DLY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TON_MIN_NS = 95; // shortest high-side pulse
	localparam int TON_MIN_CYC = (TON_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QUAL_TICKS = 2048; // oscillator ticks before keep-alive entry
	// external sync window, frequency ratio times ten
	localparam int SYNC_RATIO_MIN_X10 = 12;
	localparam int SYNC_RATIO_MAX_X10 = 15;
	localparam int OSC_DIV_DEF = 30; // base oscillator divider of clk_sys
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATE = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0c;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h01; // sync enabled
	localparam logic [7:0] MASK_RST = 8'h00;
	// control field
	localparam int CTRL_SYNC_EN = 0;
	// status event bits
	localparam int EV_SLEEP = 0;
	localparam int EV_KEEPALIVE = 1;
	localparam int EV_REDUCED = 2;
	localparam int EV_AUXRST = 3;
	localparam int EV_BOOT_OV = 4;
	localparam int EV_BOOT_UV = 5;
	localparam int EV_SKIP = 6;
	localparam int EV_W = 7;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// operating modes
	typedef enum logic [2:0] {
		ST_SLEEP,
		ST_FIXED,
		ST_QUALIFY,
		ST_KEEPALIVE,
		ST_REDUCED,
		ST_AUXRST
	} rmc_mode_t;
endpackage

/* File: hw/rmc_sync.sv */
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are slow levels, not buses that must stay coherent
// Notes: first stage is read by the second stage only
`timescale 1ns/10ps
module rmc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r; // first stage, metastability catch

	////////////////////////////////////////////////////////////////
	// two stages, both cleared at reset
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

/* File: hw/rmc_top.sv */
// Purpose: mode control of a switching regulator with AXI4-Lite registers
// Assumes: analog comparators and fault detectors arrive as digital levels
// Notes: all pin inputs pass rmc_sync before use
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module rmc_top #(
	parameter int OSC_DIV = rmc_pkg::OSC_DIV_DEF
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// host pins
	input wire logic run_req_in,
	input wire logic mode_select_input,
	// supply and analog status
	input wire logic aux_supply_ok,
	input wire logic vin_present,
	input wire logic ss_above_th,
	input wire logic vout_valid,
	input wire logic ramp_above_err,
	input wire logic err_below_offset,
	input wire logic pfm_pulse_req,
	// fault detectors
	input wire logic fault_diode_missing,
	input wire logic fault_boot_ov,
	input wire logic fault_boot_uv,
	input wire logic fault_vout_short,
	input wire logic fault_sw_short,
	input wire logic prot_fault,
	// power stage controls
	output logic hs_switch_on,
	output logic comp_pull_low,
	output logic ss_pull_low,
	output logic ilim_half,
	output logic fault_detect_en,
	// open-drain power-ok
	output logic power_ok_output_o,
	output logic power_ok_output_oe,
	// interrupt
	output logic irq
);
	localparam int SYNC_MIN_CYC = OSC_DIV * 10 / rmc_pkg::SYNC_RATIO_MAX_X10;
	localparam int SYNC_MAX_CYC = OSC_DIV * 10 / rmc_pkg::SYNC_RATIO_MIN_X10;

	////////////////////////////////////////////////////////////////
	// pin synchronisation
	logic [14:0] pin_s; // synchronised pin levels
	logic run_s, mode_s, aux_s, vin_s, ss_s, vok_s, ramp_s, errlo_s, pfm_s;
	logic dio_s, bov_s, buv_s, vsh_s, swsh_s, prot_s;
	rmc_sync #(.W(15)) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.d({run_req_in, mode_select_input, aux_supply_ok, vin_present, ss_above_th,
			vout_valid, ramp_above_err, err_below_offset, pfm_pulse_req,
			fault_diode_missing, fault_boot_ov, fault_boot_uv, fault_vout_short,
			fault_sw_short, prot_fault}),
		.q(pin_s)
	);
	assign {run_s, mode_s, aux_s, vin_s, ss_s, vok_s, ramp_s, errlo_s, pfm_s,
		dio_s, bov_s, buv_s, vsh_s, swsh_s, prot_s} = pin_s;

	logic mode_d_r; // previous mode level, edge detection
	logic mode_rise, mode_fall;
	logic ka_fault; // faults seen by the keep-alive detectors
	logic aux_lost; // bias gone while input power stays
	assign mode_rise = mode_s & ~mode_d_r;
	assign mode_fall = ~mode_s & mode_d_r;
	assign ka_fault = dio_s | bov_s | buv_s | vsh_s | swsh_s;
	assign aux_lost = vin_s & ~aux_s;

	////////////////////////////////////////////////////////////////
	// registers
	localparam int EV_W_L = rmc_pkg::EV_W; // width of status and mask
	logic [7:0] ctrl_r; // software control
	logic [EV_W_L-1:0] status_r; // sticky events
	logic [EV_W_L-1:0] mask_r; // interrupt enables
	logic [EV_W_L-1:0] ev; // event pulses this cycle
	logic [EV_W_L-1:0] st_clr; // write-one-to-clear pulses
	rmc_pkg::rmc_mode_t state_r, state_nxt;

	////////////////////////////////////////////////////////////////
	// shutdown filter: a low must persist before sleep is entered
	logic [11:0] sleep_cnt_r;
	logic asleep_r;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sleep_cnt_r <= 12'h000;
			asleep_r <= 1'b1;
		end else if (run_s) begin
			sleep_cnt_r <= 12'h000;
			asleep_r <= 1'b0;
		end else if (sleep_cnt_r == 12'(rmc_pkg::SLEEP_DLY_CYC - 1)) begin
			asleep_r <= 1'b1;
		end else begin
			sleep_cnt_r <= sleep_cnt_r + 12'h001;
		end
	end

	////////////////////////////////////////////////////////////////
	// base oscillator and external sync detection
	logic [7:0] osc_cnt_r;
	logic osc_tick;
	logic [7:0] ext_cnt_r; // clk_sys cycles since last mode rise
	logic sync_lock_r;
	logic cyc_start;
	assign osc_tick = (osc_cnt_r == 8'(OSC_DIV - 1));
	assign cyc_start = sync_lock_r ? mode_rise : osc_tick;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			osc_cnt_r <= 8'h00;
		end else if (osc_tick) begin
			osc_cnt_r <= 8'h00;
		end else begin
			osc_cnt_r <= osc_cnt_r + 8'h01;
		end
	end
	// lock only while edges keep arriving inside the window
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ext_cnt_r <= 8'hff;
			sync_lock_r <= 1'b0;
			mode_d_r <= 1'b0;
		end else begin
			mode_d_r <= mode_s;
			if (mode_rise) begin
				ext_cnt_r <= 8'h00;
				sync_lock_r <= ctrl_r[rmc_pkg::CTRL_SYNC_EN] && ext_cnt_r >= 8'(SYNC_MIN_CYC)
					&& ext_cnt_r <= 8'(SYNC_MAX_CYC);
			end else begin
				if (ext_cnt_r != 8'hff)
					ext_cnt_r <= ext_cnt_r + 8'h01;
				if (ext_cnt_r > 8'(SYNC_MAX_CYC))
					sync_lock_r <= 1'b0; // clock stopped, fall back
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// mode state machine
	logic [11:0] qual_cnt_r;
	always_comb begin
		state_nxt = state_r;
		if (aux_lost)
			state_nxt = rmc_pkg::ST_AUXRST;
		else if (asleep_r && state_r != rmc_pkg::ST_AUXRST)
			state_nxt = rmc_pkg::ST_SLEEP;
		else begin
			case (state_r)
				rmc_pkg::ST_SLEEP: state_nxt = rmc_pkg::ST_FIXED;
				rmc_pkg::ST_FIXED: begin
					if (mode_fall && ss_s && vok_s)
						state_nxt = rmc_pkg::ST_QUALIFY;
				end
				rmc_pkg::ST_QUALIFY: begin
					if (mode_rise)
						state_nxt = rmc_pkg::ST_FIXED;
					else if (osc_tick && qual_cnt_r == 12'(rmc_pkg::QUAL_TICKS - 1))
						state_nxt = ka_fault ? rmc_pkg::ST_REDUCED : rmc_pkg::ST_KEEPALIVE;
				end
				rmc_pkg::ST_KEEPALIVE: begin
					if (mode_rise)
						state_nxt = rmc_pkg::ST_FIXED;
					else if (ka_fault)
						state_nxt = rmc_pkg::ST_REDUCED;
				end
				rmc_pkg::ST_REDUCED: begin
					if (mode_rise)
						state_nxt = rmc_pkg::ST_FIXED;
					else if (!ka_fault)
						state_nxt = rmc_pkg::ST_KEEPALIVE;
				end
				rmc_pkg::ST_AUXRST: state_nxt = rmc_pkg::ST_SLEEP;
				default: state_nxt = rmc_pkg::ST_SLEEP;
			endcase
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			state_r <= rmc_pkg::ST_SLEEP;
		else
			state_r <= state_nxt;
	end
	// qualification counts oscillator ticks, not system cycles
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			qual_cnt_r <= 12'h000;
		else if (state_r != rmc_pkg::ST_QUALIFY)
			qual_cnt_r <= 12'h000;
		else if (osc_tick)
			qual_cnt_r <= qual_cnt_r + 12'h001;
	end

	////////////////////////////////////////////////////////////////
	// switching cycle flip-flop, reset-dominant
	logic pwm_ff_r, pwm_ff_nxt;
	logic [3:0] on_cnt_r; // cycles since high-side turn-on
	logic sw_allow;
	logic ff_reset;
	assign sw_allow = !prot_s && (state_r == rmc_pkg::ST_FIXED
		|| state_r == rmc_pkg::ST_QUALIFY || state_r == rmc_pkg::ST_REDUCED);
	// blanking keeps the shortest pulse; ramp compare ends it afterwards
	assign ff_reset = ramp_s && on_cnt_r >= 4'(rmc_pkg::TON_MIN_CYC - 1);
	always_comb begin
		pwm_ff_nxt = pwm_ff_r;
		if (!sw_allow)
			pwm_ff_nxt = 1'b0;
		else if (pwm_ff_r) begin
			if (ff_reset)
				pwm_ff_nxt = 1'b0;
		end else if (cyc_start && !errlo_s && !ramp_s)
			pwm_ff_nxt = 1'b1;
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pwm_ff_r <= 1'b0;
			on_cnt_r <= 4'h0;
		end else begin
			pwm_ff_r <= pwm_ff_nxt;
			if (!pwm_ff_r)
				on_cnt_r <= 4'h0;
			else if (on_cnt_r != 4'hf)
				on_cnt_r <= on_cnt_r + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// registered power stage outputs
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			hs_switch_on <= 1'b0;
			comp_pull_low <= 1'b1;
			ss_pull_low <= 1'b1;
			ilim_half <= 1'b0;
			fault_detect_en <= 1'b0;
			power_ok_output_o <= 1'b0;
			power_ok_output_oe <= 1'b1;
		end else begin
			// keep-alive pulses come from the pulse logic outside
			hs_switch_on <= (state_r == rmc_pkg::ST_KEEPALIVE) ? (pfm_s && !prot_s)
				: pwm_ff_nxt;
			comp_pull_low <= prot_s || state_r == rmc_pkg::ST_SLEEP
				|| state_r == rmc_pkg::ST_AUXRST;
			ss_pull_low <= prot_s || state_r == rmc_pkg::ST_SLEEP
				|| state_r == rmc_pkg::ST_AUXRST;
			ilim_half <= state_r == rmc_pkg::ST_REDUCED;
			fault_detect_en <= state_r == rmc_pkg::ST_FIXED || state_r == rmc_pkg::ST_QUALIFY
				|| state_r == rmc_pkg::ST_REDUCED;
			power_ok_output_o <= 1'b0;
			power_ok_output_oe <= !vok_s || state_r == rmc_pkg::ST_SLEEP
				|| state_r == rmc_pkg::ST_AUXRST;
		end
	end

	////////////////////////////////////////////////////////////////
	// events, sticky status and interrupt
	always_comb begin
		ev = '0;
		ev[rmc_pkg::EV_SLEEP] = state_nxt == rmc_pkg::ST_SLEEP && state_r != rmc_pkg::ST_SLEEP;
		ev[rmc_pkg::EV_KEEPALIVE] = state_nxt == rmc_pkg::ST_KEEPALIVE
			&& state_r != rmc_pkg::ST_KEEPALIVE;
		ev[rmc_pkg::EV_REDUCED] = state_nxt == rmc_pkg::ST_REDUCED
			&& state_r != rmc_pkg::ST_REDUCED;
		ev[rmc_pkg::EV_AUXRST] = state_nxt == rmc_pkg::ST_AUXRST
			&& state_r != rmc_pkg::ST_AUXRST;
		ev[rmc_pkg::EV_BOOT_OV] = bov_s;
		ev[rmc_pkg::EV_BOOT_UV] = buv_s;
		ev[rmc_pkg::EV_SKIP] = sw_allow && cyc_start && !pwm_ff_r && errlo_s;
	end
	// set wins over a clear in the same cycle
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			status_r <= '0;
			irq <= 1'b0;
		end else begin
			status_r <= (status_r & ~st_clr) | ev;
			irq <= |(status_r & mask_r);
		end
	end

	////////////////////////////////////////////////////////////////
	// axi4-lite slave
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = a == rmc_pkg::OFS_CTRL || a == rmc_pkg::OFS_STATE
			|| a == rmc_pkg::OFS_STATUS || a == rmc_pkg::OFS_MASK;
	endfunction
	logic [7:0] wa_r; // held write address
	logic [7:0] wd_r; // held low data byte
	logic wb_r; // held low byte strobe
	logic aw_got_r, w_got_r;
	logic do_wr;
	assign do_wr = aw_got_r && w_got_r && !s_axi_bvalid;
	assign st_clr = (do_wr && wa_r == rmc_pkg::OFS_STATUS && wb_r) ? wd_r[EV_W_L-1:0] : '0;
	// write channel: address and data in either order
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= rmc_pkg::RESP_OKAY;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			wa_r <= 8'h00;
			wd_r <= 8'h00;
			wb_r <= 1'b0;
			ctrl_r <= rmc_pkg::CTRL_RST;
			mask_r <= rmc_pkg::MASK_RST[EV_W_L-1:0];
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wa_r <= {s_axi_awaddr[7:2], 2'h0};
				aw_got_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd_r <= s_axi_wdata[7:0];
				wb_r <= s_axi_wstrb[0];
				w_got_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= reg_hit(wa_r) ? rmc_pkg::RESP_OKAY : rmc_pkg::RESP_SLVERR;
				if (wb_r && wa_r == rmc_pkg::OFS_CTRL)
					ctrl_r <= {7'h00, wd_r[rmc_pkg::CTRL_SYNC_EN]};
				if (wb_r && wa_r == rmc_pkg::OFS_MASK)
					mask_r <= wd_r[EV_W_L-1:0];
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	// read channel: data one cycle after the address is taken
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= rmc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= reg_hit({s_axi_araddr[7:2], 2'h0}) ? rmc_pkg::RESP_OKAY
				: rmc_pkg::RESP_SLVERR;
			case ({s_axi_araddr[7:2], 2'h0})
				rmc_pkg::OFS_CTRL: s_axi_rdata <= {24'h000000, ctrl_r};
				rmc_pkg::OFS_STATE: s_axi_rdata <= {22'h000000, ka_fault, prot_s,
					!power_ok_output_oe, sync_lock_r, asleep_r, 2'h0, state_r};
				rmc_pkg::OFS_STATUS: s_axi_rdata <= {25'h0000000, status_r};
				rmc_pkg::OFS_MASK: s_axi_rdata <= {25'h0000000, mask_r};
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_sleep_filter: assert property ($rose(asleep_r) |-> $past(!run_s)
		&& $past(sleep_cnt_r) == 12'(rmc_pkg::SLEEP_DLY_CYC - 1))
		else $error("sleep entered before filter expired");
	a_mode_ignored: assert property (asleep_r && !aux_lost && state_r != rmc_pkg::ST_AUXRST
		|=> state_r == rmc_pkg::ST_SLEEP)
		else $error("mode select acted while asleep");
	a_qual_count: assert property (state_r == rmc_pkg::ST_QUALIFY
		&& state_nxt == rmc_pkg::ST_KEEPALIVE |-> osc_tick
		&& qual_cnt_r == 12'(rmc_pkg::QUAL_TICKS - 1))
		else $error("keep-alive entered before 2048 ticks");
	a_fall_check: assert property (state_r == rmc_pkg::ST_FIXED && mode_fall && !(ss_s && vok_s)
		&& !asleep_r && !aux_lost |=> state_r == rmc_pkg::ST_FIXED)
		else $error("qualify started without soft-start and power-ok");
	a_reduced_ilim: assert property (state_r == rmc_pkg::ST_KEEPALIVE && ka_fault
		&& !mode_rise && !asleep_r && !aux_lost |=> ##1 ilim_half)
		else $error("fault in keep-alive did not halve the limit");
	a_aux_reset: assert property (aux_lost |=> ##1 (!hs_switch_on && power_ok_output_oe
		&& ss_pull_low && comp_pull_low))
		else $error("aux loss did not reset outputs");
	a_fault_inhibit: assert property (prot_s |=> !hs_switch_on && comp_pull_low)
		else $error("switching continued under fault");
	a_skip_cycle: assert property (!pwm_ff_r && cyc_start && errlo_s |=> !pwm_ff_r)
		else $error("cycle flop set below ramp offset");
	a_ton_min: assert property ($rose(pwm_ff_r) |-> (pwm_ff_r || $past(!sw_allow))[*3])
		else $error("high-side pulse shorter than minimum");
	a_sync_window: assert property ($rose(sync_lock_r) |-> $past(ext_cnt_r) >= 8'(SYNC_MIN_CYC)
		&& $past(ext_cnt_r) <= 8'(SYNC_MAX_CYC))
		else $error("locked to clock outside window");
	a_return_fixed: assert property (mode_rise && !asleep_r && !aux_lost
		&& state_r == rmc_pkg::ST_KEEPALIVE |=> state_r == rmc_pkg::ST_FIXED)
		else $error("rising mode did not return to fixed");
	a_boot_flag: assert property (bov_s |=> status_r[rmc_pkg::EV_BOOT_OV])
		else $error("boot overvoltage not flagged");
endmodule

/* File: bench/rmc_host_model.sv */
// Purpose: host controller model driving the run and mode pins
// Assumes: the host shares clk_sys with the regulator block
// Notes: a sync clock period is two SYNC_HALF spans of clk_sys
`timescale 1ns/10ps
module rmc_host_model #(
	parameter int SYNC_HALF = 3
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// commands from the bench
	input wire logic run_cmd,
	input wire logic mode_cmd,
	input wire logic sync_on,
	// pins toward the regulator
	output logic run_req_in,
	output logic mode_select_input
);
	int half_cnt; // cycles into the current sync half period
	////////////////////////////////////////
	// pins follow commands one edge later, like a port write
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			run_req_in <= 1'b0; // host keeps the part asleep until it boots
			mode_select_input <= 1'b1;
			half_cnt <= 0;
		end else begin
			run_req_in <= run_cmd;
			if (sync_on) begin
				// steady period only: a wandering clock would fall out of the lock window
				half_cnt <= (half_cnt == SYNC_HALF - 1) ? 0 : half_cnt + 1;
				if (half_cnt == SYNC_HALF - 1) begin
					mode_select_input <= ~mode_select_input;
				end
			end else begin
				half_cnt <= 0;
				mode_select_input <= mode_cmd;
			end
		end
	end
endmodule

/* File: bench/rmc_top_bench.sv */
// Purpose: self-checking bench of the regulator mode control block
// Assumes: OSC_DIV set to 8 so the keep-alive delay stays short
// Notes: state is observed through the state register over the bus
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("unexpected %s exp %h got %h", nm, ex, got); end end
module rmc_top_bench;
	localparam int DIV = 8; // short oscillator period
	logic clk_sys = 1'b0;
	logic sys_rst;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat, rnd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, bres, rres;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic run_req_in, mode_select_input, run_cmd, mode_cmd, sync_on;
	logic aux_supply_ok, vin_present, ss_above_th, vout_valid, ramp_above_err;
	logic err_below_offset, pfm_pulse_req, prot_fault;
	logic hs_switch_on, comp_pull_low, ss_pull_low, ilim_half, fault_detect_en;
	logic power_ok_output_o, power_ok_output_oe, irq;
	logic [4:0] kfault; // keep-alive fault levels
	wire logic fault_diode_missing = kfault[0];
	wire logic fault_boot_ov = kfault[1];
	wire logic fault_boot_uv = kfault[2];
	wire logic fault_vout_short = kfault[3];
	wire logic fault_sw_short = kfault[4];
	int n_mismatch = 0;
	int checked = 0;
	int seed, hs_n;
	rmc_top #(.OSC_DIV(DIV)) rmc_top_i (.*);
	rmc_host_model #(.SYNC_HALF(3)) rmc_host_model_i (.*);
	always #20 clk_sys = ~clk_sys;
	////////////////////////////////////////
	// keep-alive entry delay in clk_sys cycles
	function automatic int qual_cyc();
		return rmc_pkg::QUAL_TICKS * DIV;
	endfunction
	task automatic results();
		if (n_mismatch == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// a used-up wait counts as a mismatch
	task automatic bound_hit(input int n, input int lim);
		if (n > lim) begin
			n_mismatch++;
			results();
		end
	endtask
	// bus write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
			bound_hit(++n, 50);
		end
		bres = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// bus read, result left in rdat and rres
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
			bound_hit(++n, 50);
		end
		rdat = s_axi_rdata;
		rres = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// poll the state register until the mode shows up
	task automatic wait_mode(input rmc_pkg::rmc_mode_t m, input int lim);
		int n;
		n = 0;
		rd(rmc_pkg::OFS_STATE);
		while (rdat[2:0] !== m) begin
			bound_hit(++n, lim);
			rd(rmc_pkg::OFS_STATE);
		end
		checked++;
	endtask
	task automatic wait_hs(input logic v, input int lim);
		hs_n = 0;
		while (hs_switch_on !== v) begin
			@(posedge clk_sys);
			bound_hit(++hs_n, lim);
		end
	endtask
	////////////////////////////////////////
	// main sequence
	initial begin
		seed = 49221;
		sys_rst = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		{run_cmd, mode_cmd, sync_on, aux_supply_ok, vin_present} = 5'b01011;
		{ss_above_th, vout_valid, ramp_above_err, err_below_offset} = 4'b1100;
		{pfm_pulse_req, prot_fault, kfault} = '0;
		repeat (8) @(posedge clk_sys);
		`CHK("comp_rst", 1'b1, comp_pull_low)
		sys_rst <= 1'b0;
		rd(rmc_pkg::OFS_CTRL);
		`CHK("ctrl", 32'h1, rdat)
		rd(8'h10);
		`CHK("rd_unmapped", rmc_pkg::RESP_SLVERR, rres)
		wr(8'h14, 32'hff);
		`CHK("wr_unmapped", rmc_pkg::RESP_SLVERR, bres)
		rnd = $random(seed);
		wr(rmc_pkg::OFS_MASK, rnd);
		rd(rmc_pkg::OFS_MASK);
		`CHK("mask", rnd & 32'h7f, rdat)
		wr(rmc_pkg::OFS_MASK, 32'h0);
		// mode pin toggled while asleep
		mode_cmd <= 1'b0;
		repeat (20) @(posedge clk_sys);
		wait_mode(rmc_pkg::ST_SLEEP, 0);
		mode_cmd <= 1'b1;
		run_cmd <= 1'b1;
		wait_mode(rmc_pkg::ST_FIXED, 20);
		`CHK("fault_en", 1'b1, fault_detect_en)
		`CHK("comp_run", 1'b0, comp_pull_low)
		// one switching pulse cut by the ramp compare
		wait_hs(1'b1, 3 * DIV);
		ramp_above_err <= 1'b1;
		wait_hs(1'b0, 12);
		`CHK("ton_min", 1'b1, hs_n >= rmc_pkg::TON_MIN_CYC && hs_n < 9)
		ramp_above_err <= 1'b0;
		err_below_offset <= 1'b1;
		repeat (4) @(posedge clk_sys);
		hs_n = 0;
		repeat (4 * DIV) begin
			@(posedge clk_sys);
			if (hs_switch_on !== 1'b0) hs_n++;
		end
		`CHK("skip_hs", 0, hs_n)
		rd(rmc_pkg::OFS_STATUS);
		`CHK("skip_ev", 1'b1, rdat[rmc_pkg::EV_SKIP])
		err_below_offset <= 1'b0;
		prot_fault <= 1'b1;
		repeat (6) @(posedge clk_sys);
		`CHK("comp_fault", 1'b1, comp_pull_low)
		hs_n = 0;
		repeat (2 * DIV + 10) begin
			@(posedge clk_sys);
			if (hs_switch_on !== 1'b0) hs_n++;
		end
		`CHK("hs_fault", 0, hs_n)
		prot_fault <= 1'b0;
		wr(rmc_pkg::OFS_STATUS, 32'h7f);
		// falling mode without soft-start done stays fixed
		{ss_above_th, mode_cmd} <= 2'b00;
		repeat (20) @(posedge clk_sys);
		wait_mode(rmc_pkg::ST_FIXED, 0);
		mode_cmd <= 1'b1;
		repeat (20) @(posedge clk_sys);
		{ss_above_th, mode_cmd} <= 2'b10;
		wait_mode(rmc_pkg::ST_QUALIFY, 10);
		repeat (qual_cyc() - 200) @(posedge clk_sys);
		wait_mode(rmc_pkg::ST_QUALIFY, 0);
		wait_mode(rmc_pkg::ST_KEEPALIVE, 150);
		`CHK("irq_masked", 1'b0, irq)
		wr(rmc_pkg::OFS_MASK, 32'h1 << rmc_pkg::EV_KEEPALIVE);
		repeat (3) @(posedge clk_sys);
		`CHK("irq_set", 1'b1, irq)
		wr(rmc_pkg::OFS_STATUS, 32'h1 << rmc_pkg::EV_KEEPALIVE);
		repeat (3) @(posedge clk_sys);
		`CHK("irq_clr", 1'b0, irq)
		for (int i = 0; i < 5; i++) begin
			kfault <= 5'h1 << i;
			wait_mode(rmc_pkg::ST_REDUCED, 20);
			`CHK("ilim_half", 1'b1, ilim_half)
			kfault <= 5'h0;
			wait_mode(rmc_pkg::ST_KEEPALIVE, 20);
		end
		rd(rmc_pkg::OFS_STATUS);
		`CHK("boot_ev", 32'h30, rdat & 32'h30)
		// keep-alive pulses pass straight from the pulse request
		pfm_pulse_req <= 1'b1;
		repeat (4) @(posedge clk_sys);
		`CHK("ka_pulse", 1'b1, hs_switch_on)
		pfm_pulse_req <= 1'b0;
		repeat (4) @(posedge clk_sys);
		`CHK("ka_idle", 1'b0, hs_switch_on)
		mode_cmd <= 1'b1;
		wait_mode(rmc_pkg::ST_FIXED, 2);
		// external sync clock at 6 clk_sys per period
		ss_above_th <= 1'b0;
		sync_on <= 1'b1;
		repeat (10 * DIV) @(posedge clk_sys);
		rd(rmc_pkg::OFS_STATE);
		`CHK("sync_lock", 1'b1, rdat[6])
		sync_on <= 1'b0;
		// short low glitch on the run pin is filtered
		rnd = 100 + ($random(seed) & 32'h7ff);
		run_cmd <= 1'b0;
		repeat (rnd) @(posedge clk_sys);
		run_cmd <= 1'b1;
		repeat (10) @(posedge clk_sys);
		wait_mode(rmc_pkg::ST_FIXED, 0);
		run_cmd <= 1'b0;
		repeat (rmc_pkg::SLEEP_DLY_CYC - 50) @(posedge clk_sys);
		wait_mode(rmc_pkg::ST_FIXED, 0);
		wait_mode(rmc_pkg::ST_SLEEP, 40);
		`CHK("comp_sleep", 1'b1, comp_pull_low)
		// auxiliary supply lost with input power present
		run_cmd <= 1'b1;
		wait_mode(rmc_pkg::ST_FIXED, 20);
		aux_supply_ok <= 1'b0;
		repeat (6) @(posedge clk_sys);
		`CHK("aux_out", 5'b11100, {ss_pull_low, comp_pull_low, power_ok_output_oe, hs_switch_on, power_ok_output_o})
		results();
	end
endmodule
